/* File: rtl/pwmoss_cfg.svh */
// Offsets, field positions, reset values and synchronised input count for the slave
// offset synchroniser. Definitions only; included by the design files.
`ifndef PWMOSS_CFG_SVH
`define PWMOSS_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PWMOSS_ADDR_W        8
`define PWMOSS_CTRL_OFF      8'h00
`define PWMOSS_PERIOD_OFF    8'h04
`define PWMOSS_PHASE_OFF     8'h08
`define PWMOSS_STATUS_OFF    8'h0C

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define PWMOSS_EN_BIT        0
`define PWMOSS_MODE_LSB      1
`define PWMOSS_MODE_MSB      2
`define PWMOSS_DIR_BIT       3
`define PWMOSS_LDA_BIT       4

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define PWMOSS_CNT_W         16
`define PWMOSS_PERIOD_RST    16'hFFFF
`define PWMOSS_PHASE_RST     16'h0001
`define PWMOSS_CNT_ONE       16'h0001
`define PWMOSS_SYNC_IN       3

`endif

/* File: rtl/pwmoss_pkg.sv */
// Types shared by the slave offset synchroniser.
// Assumes pwmoss_cfg.svh is on the include path.
package pwmoss_pkg;

  // ----------------------------------------------------------------------
  // Offset mode select encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PWMOSS_MODE_INDEP   = 2'h0,
    PWMOSS_MODE_SYNC    = 2'h1,
    PWMOSS_MODE_ONESHOT = 2'h2,
    PWMOSS_MODE_CONT    = 2'h3
  } pwmoss_mode_type;

  // ----------------------------------------------------------------------
  // Slave counter states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PWMOSS_ST_STOP = 3'h1,
    PWMOSS_ST_WAIT = 3'h2,
    PWMOSS_ST_RUN  = 3'h4
  } pwmoss_state_type;

endpackage

/* File: rtl/pwmoss_slave_sync.sv */
// Slave side offset synchroniser for a PWM period counter, with an
// AHB-Lite register slave. Assumes one clock (the slave PWM clock) and a
// master PWM module that toggles one wire per up-count and one per
// down-count offset match.
//
// Behaviour
// - Mode 00: counter runs while enabled, ignores master; period returns it to zero.
// - Mode 01: counter holds until master match, then runs until enable clears.
// - Sync start: each period event zeroes counter, counting continues without master.
// - Mode 10: after master match, count up from current value to period match.
// - One-shot: period event zeroes and halts counter; next master match restarts it.
// - One-shot: master match during the triggered period is ignored.
// - Mode 11: counter inhibited after enable; first master match starts it.
// - Continuous mode: later master matches load counter with one, counting on.
// - Continuous mode: period event before next match zeroes counter, counting on.
// - Switching to mode 00 while running keeps the existing offset.
// - Center-aligned master: match on up-count if direction clear, down if set.
// - Direction bit ignored when master is not center-aligned.
// - While running, new direction waits in a buffer until load-arm is set.
`timescale 1ns/1ps
`include "pwmoss_cfg.svh"

module pwmoss_slave_sync
  import pwmoss_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic [31:0]                   hrdata,
  output logic                          hresp,
  input  wire logic                     match_up_toggle,
  input  wire logic                     match_down_toggle,
  input  wire logic                     master_center_aligned,
  output logic [`PWMOSS_CNT_W-1:0]      slave_period_counter,
  output logic                          period_event,
  output logic                          phase_event,
  output logic                          counter_running
);

  // ----------------------------------------------------------------------
  // Decoding helper
  // ----------------------------------------------------------------------
  function automatic logic addr_is(input logic [`PWMOSS_ADDR_W-1:0] a,
                                   input logic [`PWMOSS_ADDR_W-1:0] off);
    addr_is = (a == off);
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic                        pend_reg;
  logic                        wr_reg;
  logic [`PWMOSS_ADDR_W-1:0]   addr_reg;
  logic                        hreadyout_reg;
  logic [31:0]                 hrdata_reg;
  logic                        hresp_reg;
  logic                        enable_reg;
  pwmoss_mode_type             mode_reg;
  logic                        dir_buf_reg;
  logic                        dir_act_reg;
  logic                        dir_act_next;
  logic                        load_arm_reg;
  logic                        load_arm_next;
  logic [`PWMOSS_CNT_W-1:0]    period_reg;
  logic [`PWMOSS_CNT_W-1:0]    phase_reg;
  logic [`PWMOSS_CNT_W-1:0]    cnt_reg;
  logic [`PWMOSS_CNT_W-1:0]    cnt_next;
  pwmoss_state_type            state_reg;
  pwmoss_state_type            state_next;
  logic                        period_evt_reg;
  logic                        phase_evt_reg;
  logic [`PWMOSS_SYNC_IN-1:0]  sync_in;
  logic [`PWMOSS_SYNC_IN-1:0]  sync1_reg;
  logic [`PWMOSS_SYNC_IN-1:0]  sync2_reg;
  logic [1:0]                  last_reg;
  logic [31:0]                 rd_mux;

  // ----------------------------------------------------------------------
  // AHB-Lite slave: one wait state on every transfer
  // ----------------------------------------------------------------------
  wire accept    = hsel & hready & htrans[1];
  wire wr_strobe = pend_reg & wr_reg;
  wire rd_strobe = pend_reg & ~wr_reg;
  wire ctrl_wr   = wr_strobe & addr_is(addr_reg, `PWMOSS_CTRL_OFF);
  wire period_wr = wr_strobe & addr_is(addr_reg, `PWMOSS_PERIOD_OFF);
  wire phase_wr  = wr_strobe & addr_is(addr_reg, `PWMOSS_PHASE_OFF);

  wire st_stop = state_reg == PWMOSS_ST_STOP;
  wire st_wait = state_reg == PWMOSS_ST_WAIT;
  wire st_run  = state_reg == PWMOSS_ST_RUN;

  wire [31:0] ctrl_word   = {27'h0000000, load_arm_reg, dir_buf_reg, mode_reg, enable_reg};
  wire [31:0] status_word = {13'h0000, dir_act_reg, st_wait, st_run, cnt_reg};

  // Unmapped offsets read as zero; writes to them are dropped
  assign rd_mux = addr_is(addr_reg, `PWMOSS_CTRL_OFF)   ? ctrl_word :
                  addr_is(addr_reg, `PWMOSS_PERIOD_OFF) ? {16'h0000, period_reg} :
                  addr_is(addr_reg, `PWMOSS_PHASE_OFF)  ? {16'h0000, phase_reg} :
                  addr_is(addr_reg, `PWMOSS_STATUS_OFF) ? status_word : 32'h00000000;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_reg      <= 1'b0;
      wr_reg        <= 1'b0;
      addr_reg      <= 8'h00;
      hreadyout_reg <= 1'b1;
      hrdata_reg    <= 32'h00000000;
      hresp_reg     <= 1'b0;
    end
    else
    begin
      pend_reg      <= accept;
      hreadyout_reg <= ~accept;
      hresp_reg     <= 1'b0;
      if (accept)
      begin
        addr_reg <= haddr[`PWMOSS_ADDR_W-1:0];
        wr_reg   <= hwrite;
      end
      if (rd_strobe)
      begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Software controls
  // ----------------------------------------------------------------------
  // Arm is cleared by the transfer it triggers; a new arm in the same cycle wins
  assign load_arm_next = ctrl_wr & hwdata[`PWMOSS_LDA_BIT];
  // Stopped: direction applies at once; running: only through load-arm
  assign dir_act_next  = (load_arm_reg | st_stop) ? dir_buf_reg : dir_act_reg;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_reg   <= 1'b0;
      mode_reg     <= PWMOSS_MODE_INDEP;
      dir_buf_reg  <= 1'b0;
      dir_act_reg  <= 1'b0;
      load_arm_reg <= 1'b0;
      period_reg   <= `PWMOSS_PERIOD_RST;
      phase_reg    <= `PWMOSS_PHASE_RST;
    end
    else
    begin
      load_arm_reg <= load_arm_next;
      dir_act_reg  <= dir_act_next;
      if (ctrl_wr)
      begin
        enable_reg  <= hwdata[`PWMOSS_EN_BIT];
        mode_reg    <= pwmoss_mode_type'(hwdata[`PWMOSS_MODE_MSB:`PWMOSS_MODE_LSB]);
        dir_buf_reg <= hwdata[`PWMOSS_DIR_BIT];
      end
      if (period_wr)
      begin
        period_reg <= hwdata[`PWMOSS_CNT_W-1:0];
      end
      if (phase_wr)
      begin
        phase_reg <= hwdata[`PWMOSS_CNT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Master event synchronisers
  // ----------------------------------------------------------------------
  // Toggles, not pulses: a short master pulse could fall between slave edges
  assign sync_in = {master_center_aligned, match_down_toggle, match_up_toggle};

  genvar gi;
  generate
    for (gi = 0; gi < `PWMOSS_SYNC_IN; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end
        else
        begin
          sync1_reg[gi] <= sync_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  wire up_evt = sync2_reg[0] ^ last_reg[0];
  wire dn_evt = sync2_reg[1] ^ last_reg[1];
  wire center = sync2_reg[2];
  // Center-aligned picks one count direction; otherwise any match counts
  wire match_q = center ? (dir_act_reg ? dn_evt : up_evt)
                        : (up_evt | dn_evt);

  // ----------------------------------------------------------------------
  // Slave counter state machine
  // ----------------------------------------------------------------------
  wire period_hit = cnt_reg == period_reg;
  wire is_indep   = mode_reg == PWMOSS_MODE_INDEP;
  wire is_oneshot = mode_reg == PWMOSS_MODE_ONESHOT;
  wire is_cont    = mode_reg == PWMOSS_MODE_CONT;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PWMOSS_ST_STOP:
      begin
        if (enable_reg)
        begin
          state_next = is_indep ? PWMOSS_ST_RUN : PWMOSS_ST_WAIT;
        end
      end
      PWMOSS_ST_WAIT:
      begin
        if (!enable_reg)
        begin
          state_next = PWMOSS_ST_STOP;
        end
        else if (is_indep | match_q)
        begin
          state_next = PWMOSS_ST_RUN;
        end
      end
      PWMOSS_ST_RUN:
      begin
        if (!enable_reg)
        begin
          state_next = PWMOSS_ST_STOP;
        end
        else if (is_oneshot & period_hit)
        begin
          state_next = PWMOSS_ST_WAIT;
        end
      end
      default:
      begin
        state_next = PWMOSS_ST_STOP;
      end
    endcase
  end

  // A mode change never touches the count, so an offset already built
  // up survives a switch to independent mode
  always_comb
  begin
    cnt_next = cnt_reg;
    if (!enable_reg)
    begin
      cnt_next = '0;
    end
    else if (st_run)
    begin
      if (is_cont & match_q)
      begin
        cnt_next = `PWMOSS_CNT_ONE;
      end
      else if (period_hit)
      begin
        cnt_next = '0;
      end
      else
      begin
        cnt_next = cnt_reg + `PWMOSS_CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg      <= PWMOSS_ST_STOP;
      cnt_reg        <= '0;
      period_evt_reg <= 1'b0;
      phase_evt_reg  <= 1'b0;
      last_reg       <= 2'h0;
    end
    else
    begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      period_evt_reg <= st_run & enable_reg & period_hit;
      phase_evt_reg  <= st_run & enable_reg & (cnt_reg == phase_reg);
      last_reg       <= sync2_reg[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hreadyout            = hreadyout_reg;
  assign hrdata               = hrdata_reg;
  assign hresp                = hresp_reg;
  assign slave_period_counter = cnt_reg;
  assign period_event         = period_evt_reg;
  assign phase_event          = phase_evt_reg;
  assign counter_running      = state_reg[2];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence run_mid_s;
    st_run && enable_reg && !period_hit;
  endsequence

  sequence oneshot_end_s;
    st_run && enable_reg && is_oneshot && period_hit;
  endsequence

  indep_count_a: assert property (
    (is_indep and run_mid_s) |=> (cnt_reg == $past(cnt_reg) + `PWMOSS_CNT_ONE) && st_run)
    else $error("independent mode counter did not advance");
  sync_hold_a: assert property (
    (st_wait && enable_reg && mode_reg == PWMOSS_MODE_SYNC && !match_q)
      |=> $stable(cnt_reg) && !st_run)
    else $error("sync start counter moved without master match");
  sync_wrap_a: assert property (
    (st_run && enable_reg && mode_reg == PWMOSS_MODE_SYNC && period_hit)
      |=> cnt_reg == '0 ##1 (!enable_reg || cnt_reg == `PWMOSS_CNT_ONE))
    else $error("sync start counter did not wrap and continue");
  oneshot_halt_a: assert property (
    oneshot_end_s ##1 (enable_reg && !match_q && is_oneshot)
      |-> st_wait && cnt_reg == '0 ##1 cnt_reg == '0)
    else $error("one-shot counter did not halt at zero");
  oneshot_ignore_a: assert property (
    (is_oneshot and run_mid_s and match_q)
      |=> cnt_reg == $past(cnt_reg) + `PWMOSS_CNT_ONE)
    else $error("one-shot counter reacted to early master match");
  cont_start_a: assert property (
    (st_wait && enable_reg && is_cont) |=> st_run == $past(match_q))
    else $error("continuous mode start not tied to master match");
  cont_reload_a: assert property (
    (st_run && enable_reg && is_cont && match_q) |=> cnt_reg == `PWMOSS_CNT_ONE)
    else $error("continuous mode did not reload one on match");
  cont_wrap_a: assert property (
    (st_run && enable_reg && is_cont && period_hit && !match_q) |=> cnt_reg == '0)
    else $error("continuous mode did not zero on period");
  dir_load_a: assert property (
    (st_run && !load_arm_reg && $changed(dir_buf_reg)) |=> $stable(dir_act_reg))
    else $error("direction changed while running without load-arm");
  match_pulse_a: assert property (
    (up_evt |=> !up_evt) and (dn_evt |=> !dn_evt))
    else $error("offset match pulse lasted more than one cycle");
endmodule

/* File: verif/pwmoss_master_model.sv */
// Partner model of the master PWM offset-match source.
// Assumes it shares clk_sys with the slave and is fired by the bench.
`timescale 1ns/1ps

module pwmoss_master_model
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       fire_up,
  input  wire logic       fire_down,
  input  wire logic [1:0] lag,
  output logic            match_up_toggle,
  output logic            match_down_toggle
);
  logic [3:0] up_pipe;
  logic [3:0] down_pipe;

  // ----------------------------------------------------------------------
  // Match toggles, prompt or up to three edges late
  // ----------------------------------------------------------------------
  // Same clock as the slave, so the slave never runs faster
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_pipe           <= 4'h0;
      down_pipe         <= 4'h0;
      match_up_toggle   <= 1'h0;
      match_down_toggle <= 1'h0;
    end
    else
    begin
      up_pipe   <= {up_pipe[2:0], fire_up};
      down_pipe <= {down_pipe[2:0], fire_down};
      // Matches only on command, never tied to an equal slave period
      if (up_pipe[lag])
        match_up_toggle <= ~match_up_toggle;
      if (down_pipe[lag])
        match_down_toggle <= ~match_down_toggle;
    end
  end
endmodule

/* File: verif/pwmoss_slave_sync_tb_top.sv */
// Self-checking bench for the slave offset synchroniser.
// Assumes pwmoss_cfg.svh on the include path and the master model beside it.
`timescale 1ns/1ps
`include "pwmoss_cfg.svh"

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, (g), (e)); end end

module pwmoss_slave_sync_tb_top;
  logic                    clk_sys;
  logic                    rst_n;
  logic                    hsel;
  logic [31:0]             haddr;
  logic [1:0]              htrans;
  logic                    hwrite;
  logic [2:0]              hsize;
  logic [31:0]             hwdata;
  logic                    hreadyout;
  logic [31:0]             hrdata;
  logic                    fire_up;
  logic                    fire_down;
  logic [1:0]              lag;
  logic                    up_tgl;
  logic                    down_tgl;
  logic                    master_center_aligned;
  logic [`PWMOSS_CNT_W-1:0] slave_period_counter;
  logic [`PWMOSS_CNT_W-1:0] snap;
  logic                    period_event;
  logic                    counter_running;
  logic                    hresp;
  logic                    phase_event;
  logic [31:0]             rdv;
  int                      fail_count;
  int                      samples_checked;

  pwmoss_slave_sync i_pwmoss_slave_sync (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .match_up_toggle(up_tgl), .match_down_toggle(down_tgl),
    .master_center_aligned(master_center_aligned),
    .slave_period_counter(slave_period_counter), .period_event(period_event),
    .phase_event(phase_event), .counter_running(counter_running));

  pwmoss_master_model i_pwmoss_master_model (
    .clk_sys(clk_sys), .rst_n(rst_n), .fire_up(fire_up), .fire_down(fire_down),
    .lag(lag), .match_up_toggle(up_tgl), .match_down_toggle(down_tgl));

  initial
  begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  function automatic logic seen(input int kind);
    case (kind)
      0: seen = counter_running;
      1: seen = period_event;
      2: seen = (slave_period_counter === `PWMOSS_CNT_ONE);
      default: seen = hreadyout;
    endcase
  endfunction

  // Bounded wait; values seen are those sampled at the edge
  task automatic wait_until(input int kind, input int bound);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (seen(kind) !== 1'h1 && n < bound);
    if (seen(kind) !== 1'h1)
    begin
      fail_count++;
      stop_test();
    end
  endtask

  // ----------------------------------------------------------------------
  // AHB-Lite single word transfer
  // ----------------------------------------------------------------------
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_until(3, 20);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_until(3, 20);
    rd = hrdata;
    `CHK(hresp, 1'h0)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'h1, a, d, rdv);
  endtask

  task automatic fire(input logic up);
    if (up)
      fire_up <= 1'h1;
    else
      fire_down <= 1'h1;
    @(posedge clk_sys);
    fire_up   <= 1'h0;
    fire_down <= 1'h0;
  endtask

  // A match that must leave the count running on untouched
  task automatic no_reload(input logic up);
    snap = slave_period_counter;
    fire(up);
    step(8);
    `CHK(slave_period_counter, snap + 16'h0009)
  endtask

  // A match that must bring the count back to one
  task automatic reload(input logic up);
    step(10);
    fire(up);
    wait_until(2, 12);
    step(3);
    `CHK({phase_event, slave_period_counter}, 17'h10004)
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    rst_n = 1'h0;
    {hsel, hwrite, fire_up, fire_down, master_center_aligned} = 5'h00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    lag = 2'h0;
    fail_count = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    `CHK({hreadyout, hresp, counter_running}, 3'h4)
    `CHK({period_event, phase_event, slave_period_counter}, 18'h00000)
    `CHK(hrdata, 32'h00000000)
    ahb(1'h0, `PWMOSS_PERIOD_OFF, 32'h0, rdv);
    `CHK(rdv, {16'h0000, `PWMOSS_PERIOD_RST})
    ahb(1'h0, `PWMOSS_PHASE_OFF, 32'h0, rdv);
    `CHK(rdv, {16'h0000, `PWMOSS_PHASE_RST})
    ahb(1'h0, `PWMOSS_CTRL_OFF, 32'h0, rdv);
    `CHK(rdv, 32'h0)
    wr(8'h10, 32'hFFFFFFFF);
    ahb(1'h0, 8'h10, 32'h0, rdv);
    `CHK(rdv, 32'h0)
    wr(`PWMOSS_PERIOD_OFF, 32'h64);
    wr(`PWMOSS_CTRL_OFF, 32'h1);
    wait_until(1, 120);
    `CHK(slave_period_counter, 16'h0000)
    no_reload(1'h1);
    wr(`PWMOSS_CTRL_OFF, 32'h0);
    step(2);
    `CHK({counter_running, slave_period_counter}, 17'h0)
    lag <= 2'h3;
    wr(`PWMOSS_PERIOD_OFF, 32'h5);
    wr(`PWMOSS_CTRL_OFF, 32'h3);
    step(6);
    `CHK(counter_running, 1'h0)
    fire(1'h1);
    wait_until(0, 12);
    wait_until(1, 12);
    `CHK(slave_period_counter, 16'h0000)
    step(3);
    `CHK({counter_running, slave_period_counter}, 17'h10003)
    lag <= 2'h0;
    wr(`PWMOSS_CTRL_OFF, 32'h0);
    wr(`PWMOSS_PERIOD_OFF, 32'h1E);
    wr(`PWMOSS_CTRL_OFF, 32'h5);
    step(6);
    `CHK(counter_running, 1'h0)
    fire(1'h1);
    wait_until(0, 10);
    no_reload(1'h1);
    wait_until(1, 40);
    step(4);
    `CHK({counter_running, slave_period_counter}, 17'h0)
    fire(1'h1);
    wait_until(0, 10);
    wr(`PWMOSS_CTRL_OFF, 32'h0);
    wr(`PWMOSS_PERIOD_OFF, 32'hC8);
    wr(`PWMOSS_PHASE_OFF, 32'h3);
    wr(`PWMOSS_CTRL_OFF, 32'h7);
    step(6);
    `CHK(counter_running, 1'h0)
    fire(1'h1);
    wait_until(0, 10);
    reload(1'h1);
    wait_until(1, 220);
    `CHK(slave_period_counter, 16'h0000)
    step(2);
    `CHK(slave_period_counter, 16'h0002)
    snap = slave_period_counter;
    wr(`PWMOSS_CTRL_OFF, 32'h1);
    step(5);
    `CHK(slave_period_counter, snap + 16'h0008)
    wr(`PWMOSS_CTRL_OFF, 32'h0);
    master_center_aligned <= 1'h1;
    wr(`PWMOSS_CTRL_OFF, 32'hF);
    fire(1'h1);
    step(8);
    `CHK(counter_running, 1'h0)
    fire(1'h0);
    wait_until(0, 10);
    wr(`PWMOSS_CTRL_OFF, 32'h7);
    ahb(1'h0, `PWMOSS_STATUS_OFF, 32'h0, rdv);
    `CHK(rdv[18], 1'h1)
    wr(`PWMOSS_CTRL_OFF, 32'h17);
    ahb(1'h0, `PWMOSS_STATUS_OFF, 32'h0, rdv);
    `CHK(rdv[18], 1'h0)
    no_reload(1'h0);
    reload(1'h1);
    master_center_aligned <= 1'h0;
    reload(1'h0);
    wr(`PWMOSS_CTRL_OFF, 32'h0);
    stop_test();
  end
endmodule
